// ==== common/utc_defines.svh ====
// Register offsets, field positions, reset values and counts of the UART channel
`ifndef UTC_DEFINES_SVH
`define UTC_DEFINES_SVH
// Byte offsets
`define UTC_OFF_CMD 8'h00
`define UTC_OFF_MR0 8'h04
`define UTC_OFF_MR1 8'h08
`define UTC_OFF_MR2 8'h0C
`define UTC_OFF_STAT 8'h10
`define UTC_OFF_DATA 8'h14
`define UTC_OFF_IMR 8'h18
`define UTC_OFF_TCS 8'h1C
`define UTC_OFF_RCS 8'h20
`define UTC_OFF_DIV 8'h24
`define UTC_OFF_BID 8'h28
// Command bits
`define UTC_CMD_TX_EN 0
`define UTC_CMD_TX_DIS 1
`define UTC_CMD_TX_RST 2
`define UTC_CMD_BRK_ON 3
`define UTC_CMD_BRK_OFF 4
`define UTC_CMD_RX_EN 5
`define UTC_CMD_RX_DIS 6
`define UTC_CMD_RX_RST 7
`define UTC_CMD_OVR_CLR 8
// Status bits
`define UTC_ST_RX_RDY 0
`define UTC_ST_RX_FULL 1
`define UTC_ST_SPACE 2
`define UTC_ST_DRAINED 3
`define UTC_ST_OVR 4
`define UTC_ST_TX_EN 5
`define UTC_ST_BRK 6
// Mode fields
`define UTC_MR0_LVL_LO 4
`define UTC_MR1_PAR_EN 2
`define UTC_MR1_PAR_ODD 3
`define UTC_MR1_STOP2 4
`define UTC_MR2_CTS 4
`define UTC_MR2_RTS 5
`define UTC_CS_EXT 0
`define UTC_CS_ONE_X 1
// Counts and reset values
`define UTC_QUEUE_FULL 9'h100
`define UTC_LVL_240 9'h0F0
`define UTC_LVL_16 9'h010
`define UTC_START_CHECK 4'h7
`define UTC_SUB_LAST 4'hF
`define UTC_DIV_RST 16'h000F
`endif

// ==== common/utc_pkg.sv ====
// Types of the UART channel
package utc_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h3,
		TX_PAR = 3'h2,
		TX_STOP = 3'h6
	} utc_tx_state_type;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_PAR = 3'h2,
		RX_STOP = 3'h6
	} utc_rx_state_type;
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} utc_av_req_type;
	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} utc_av_rsp_type;
	typedef struct packed {
		logic waitrequest;
		logic [31:0] rdata;
		logic tx_en;
		logic brk;
		logic [7:0] mr0;
		logic [7:0] mr1;
		logic [7:0] mr2;
		logic [7:0] interrupt_mask_reg;
		logic [7:0] tcs;
		logic [7:0] rcs;
		logic [15:0] div;
		logic [15:0] divcnt;
		logic [255:0][7:0] txq;
		logic [7:0] twp;
		logic [7:0] trp;
		logic [8:0] tcnt;
		utc_tx_state_type ts;
		logic [3:0] tsub;
		logic [2:0] tbit;
		logic [7:0] tsh;
		logic tpar;
		logic stop2;
		logic tline;
		logic txd;
		logic rts_n;
		logic irq_n;
		logic space;
		logic drained;
		logic [7:0] bid;
		logic bid_v;
		logic [2:0] rxs;
		logic [2:0] ctss;
		logic [2:0] ecs;
		logic rxf;
		logic ctsf;
		logic ecf;
		logic ecprev;
		logic rx_en;
		logic rarm;
		utc_rx_state_type rs;
		logic [3:0] rsub;
		logic [2:0] rbit;
		logic [7:0] rsh;
		logic rperr;
		logic [255:0][10:0] rxq;
		logic [7:0] rwp;
		logic [7:0] rrp;
		logic [8:0] rcnt;
		logic ovr;
	} utc_state_type;
endpackage

// ==== rtl/utc_channel.sv ====
// UART channel: transmit queue and serialiser, receiver with queue, Avalon-MM registers
`include "utc_defines.svh"
module utc_channel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register bus
	input wire utc_pkg::utc_av_req_type av_i,
	output utc_pkg::utc_av_rsp_type av_o,
	// Serial link and flow control
	input wire logic rxd_i,
	input wire logic aux_pin_zero_i,
	input wire logic ext_clk_i,
	output logic txd_o,
	output logic send_request_n_o,
	// Interrupt and bid
	output logic host_interrupt_n_o,
	output logic [7:0] tx_bid_o,
	output logic tx_bid_valid_o
);
	import utc_pkg::*;

	utc_state_type r;
	utc_state_type next_r;
	logic bus_rd;
	logic bus_wr;
	logic ext_edge;
	logic itick;
	logic ttick;
	logic rtick;
	logic one_x;
	logic bend;
	logic rbend;
	logic [2:0] last_bit;

	function automatic logic [7:0] len_mask(input logic [1:0] sel);
		len_mask = 8'hFF >> (2'h3 - sel);
	endfunction

	assign bus_rd = av_i.read & ~r.waitrequest;
	assign bus_wr = av_i.write & ~r.waitrequest & av_i.byteenable[0];
	assign ext_edge = r.ecf & ~r.ecprev;
	assign itick = (r.divcnt == 16'h0000);
	assign ttick = r.tcs[`UTC_CS_EXT] ? ext_edge : itick;
	assign rtick = r.rcs[`UTC_CS_EXT] ? ext_edge : itick;
	assign one_x = r.tcs[`UTC_CS_EXT] & r.tcs[`UTC_CS_ONE_X];
	assign bend = ttick & (one_x | (r.tsub == `UTC_SUB_LAST));
	assign rbend = rtick & (r.rsub == `UTC_SUB_LAST);
	assign last_bit = {1'b1, r.mr1[1:0]};

	assign av_o.waitrequest = r.waitrequest;
	assign av_o.readdata = r.rdata;
	assign txd_o = r.txd;
	assign send_request_n_o = r.rts_n;
	assign host_interrupt_n_o = r.irq_n;
	assign tx_bid_o = r.bid;
	assign tx_bid_valid_o = r.bid_v;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [8:0] cmd;
		logic tx_push;
		logic tx_pop;
		logic rx_push;
		logic rx_pop;
		logic [10:0] rx_word;
		logic [31:0] rd_mux;
		next_r = r;
		cmd = 9'h000;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_word = 11'h000;
		rd_mux = 32'h0000_0000;
		// Pin synchronisers with agreement filter
		next_r.rxs = {r.rxs[1:0], rxd_i};
		next_r.ctss = {r.ctss[1:0], aux_pin_zero_i};
		next_r.ecs = {r.ecs[1:0], ext_clk_i};
		if (r.rxs[1] == r.rxs[2]) begin
			next_r.rxf = r.rxs[2];
		end
		if (r.ctss[1] == r.ctss[2]) begin
			next_r.ctsf = r.ctss[2];
		end
		if (r.ecs[1] == r.ecs[2]) begin
			next_r.ecf = r.ecs[2];
		end
		next_r.ecprev = r.ecf;
		// Internal 16x tick divider
		next_r.divcnt = itick ? r.div : r.divcnt - 16'h0001;
		// Register read mux
		case (av_i.address)
			`UTC_OFF_MR0: rd_mux = {24'h0, r.mr0};
			`UTC_OFF_MR1: rd_mux = {24'h0, r.mr1};
			`UTC_OFF_MR2: rd_mux = {24'h0, r.mr2};
			`UTC_OFF_STAT: begin
				rd_mux[`UTC_ST_RX_RDY] = (r.rcnt != 9'h000);
				rd_mux[`UTC_ST_RX_FULL] = (r.rcnt == `UTC_QUEUE_FULL);
				rd_mux[`UTC_ST_SPACE] = r.space;
				rd_mux[`UTC_ST_DRAINED] = r.drained;
				rd_mux[`UTC_ST_OVR] = r.ovr;
				rd_mux[`UTC_ST_TX_EN] = r.tx_en;
				rd_mux[`UTC_ST_BRK] = r.brk;
			end
			`UTC_OFF_DATA: rd_mux = (r.rcnt != 9'h000) ? {21'h0, r.rxq[r.rrp]} : 32'h0;
			`UTC_OFF_IMR: rd_mux = {24'h0, r.interrupt_mask_reg};
			`UTC_OFF_TCS: rd_mux = {24'h0, r.tcs};
			`UTC_OFF_RCS: rd_mux = {24'h0, r.rcs};
			`UTC_OFF_DIV: rd_mux = {16'h0, r.div};
			`UTC_OFF_BID: rd_mux = {23'h0, r.bid_v, r.bid};
			default: rd_mux = 32'h0000_0000;
		endcase
		// Bus handshake: one wait cycle
		next_r.waitrequest = 1'b1;
		if ((av_i.read | av_i.write) & r.waitrequest) begin
			next_r.waitrequest = 1'b0;
			next_r.rdata = rd_mux;
		end
		if (bus_rd && av_i.address == `UTC_OFF_DATA && r.rcnt != 9'h000) begin
			rx_pop = 1'b1;
		end
		if (bus_wr) begin
			case (av_i.address)
				`UTC_OFF_CMD: cmd = av_i.writedata[8:0];
				`UTC_OFF_MR0: next_r.mr0 = av_i.writedata[7:0];
				`UTC_OFF_MR1: next_r.mr1 = av_i.writedata[7:0];
				`UTC_OFF_MR2: next_r.mr2 = av_i.writedata[7:0];
				`UTC_OFF_DATA: tx_push = r.tx_en & (r.tcnt != `UTC_QUEUE_FULL);
				`UTC_OFF_IMR: next_r.interrupt_mask_reg = av_i.writedata[7:0];
				`UTC_OFF_TCS: next_r.tcs = av_i.writedata[7:0];
				`UTC_OFF_RCS: next_r.rcs = av_i.writedata[7:0];
				`UTC_OFF_DIV: begin
					next_r.div[7:0] = av_i.writedata[7:0];
					if (av_i.byteenable[1]) begin
						next_r.div[15:8] = av_i.writedata[15:8];
					end
				end
				default: cmd = 9'h000;
			endcase
		end
		// Commands
		if (cmd[`UTC_CMD_TX_EN]) begin
			next_r.tx_en = 1'b1;
		end
		if (cmd[`UTC_CMD_TX_DIS]) begin
			next_r.tx_en = 1'b0;
		end
		if (cmd[`UTC_CMD_BRK_ON]) begin
			next_r.brk = 1'b1;
		end
		if (cmd[`UTC_CMD_BRK_OFF]) begin
			next_r.brk = 1'b0;
		end
		if (cmd[`UTC_CMD_RX_EN]) begin
			next_r.rx_en = 1'b1;
		end
		if (cmd[`UTC_CMD_RX_DIS]) begin
			next_r.rx_en = 1'b0;
		end
		if (cmd[`UTC_CMD_OVR_CLR]) begin
			next_r.ovr = 1'b0;
		end
		////////////////////////////////////////////////////////////////////////
		// Transmitter, keeps draining the queue after disable
		if (ttick) begin
			next_r.tsub = r.tsub + 4'h1;
		end
		case (r.ts)
			TX_IDLE: begin
				next_r.tline = 1'b1;
				if (ttick && r.tcnt != 9'h000 && !(r.mr2[`UTC_MR2_CTS] && r.ctsf)) begin
					tx_pop = 1'b1;
					next_r.tsh = r.txq[r.trp] & len_mask(r.mr1[1:0]);
					next_r.tpar = ^(r.txq[r.trp] & len_mask(r.mr1[1:0])) ^ r.mr1[`UTC_MR1_PAR_ODD];
					next_r.tsub = 4'h0;
					next_r.ts = TX_START;
					next_r.tline = 1'b0;
				end
			end
			TX_START: begin
				if (bend) begin
					next_r.ts = TX_DATA;
					next_r.tbit = 3'h0;
					next_r.tline = r.tsh[0];
				end
			end
			TX_DATA: begin
				if (bend) begin
					if (r.tbit == last_bit) begin
						next_r.stop2 = r.mr1[`UTC_MR1_STOP2];
						if (r.mr1[`UTC_MR1_PAR_EN]) begin
							next_r.ts = TX_PAR;
							next_r.tline = r.tpar;
						end else begin
							next_r.ts = TX_STOP;
							next_r.tline = 1'b1;
						end
					end else begin
						next_r.tbit = r.tbit + 3'h1;
						next_r.tsh = r.tsh >> 1;
						next_r.tline = r.tsh[1];
					end
				end
			end
			TX_PAR: begin
				if (bend) begin
					next_r.ts = TX_STOP;
					next_r.tline = 1'b1;
				end
			end
			TX_STOP: begin
				if (bend) begin
					if (r.stop2) begin
						next_r.stop2 = 1'b0;
					end else begin
						next_r.ts = TX_IDLE;
					end
				end
			end
			default: next_r.ts = TX_IDLE;
		endcase
		////////////////////////////////////////////////////////////////////////
		// Receiver, 16x sampling aligned to the start edge
		if (r.rxf) begin
			next_r.rarm = 1'b1;
		end
		if (rtick) begin
			next_r.rsub = r.rsub + 4'h1;
		end
		case (r.rs)
			RX_IDLE: begin
				if (r.rx_en && rtick && r.rarm && !r.rxf) begin
					next_r.rs = RX_START;
					next_r.rsub = 4'h0;
					next_r.rarm = 1'b0;
				end
			end
			RX_START: begin
				if (rtick && r.rsub == `UTC_START_CHECK) begin
					next_r.rsub = 4'h0;
					next_r.rbit = 3'h0;
					next_r.rsh = 8'h00;
					next_r.rperr = 1'b0;
					next_r.rs = r.rxf ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rbend) begin
					next_r.rsh[r.rbit] = r.rxf;
					next_r.rbit = r.rbit + 3'h1;
					if (r.rbit == last_bit) begin
						next_r.rs = r.mr1[`UTC_MR1_PAR_EN] ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rbend) begin
					next_r.rperr = (^r.rsh ^ r.mr1[`UTC_MR1_PAR_ODD]) != r.rxf;
					next_r.rs = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rbend) begin
					rx_word = {(r.rsh == 8'h00) & ~r.rxf, (r.rsh != 8'h00) & ~r.rxf,
						r.rperr, r.rsh};
					if (r.rcnt == `UTC_QUEUE_FULL && !rx_pop) begin
						next_r.ovr = 1'b1;
					end else begin
						rx_push = 1'b1;
					end
					next_r.rs = RX_IDLE;
				end
			end
			default: next_r.rs = RX_IDLE;
		endcase
		////////////////////////////////////////////////////////////////////////
		// Queues
		if (tx_push) begin
			next_r.txq[r.twp] = av_i.writedata[7:0];
			next_r.twp = r.twp + 8'h01;
		end
		if (tx_pop) begin
			next_r.trp = r.trp + 8'h01;
		end
		next_r.tcnt = r.tcnt + {8'h00, tx_push} - {8'h00, tx_pop};
		if (rx_push) begin
			next_r.rxq[r.rwp] = rx_word;
			next_r.rwp = r.rwp + 8'h01;
		end
		if (rx_pop) begin
			next_r.rrp = r.rrp + 8'h01;
		end
		next_r.rcnt = r.rcnt + {8'h00, rx_push} - {8'h00, rx_pop};
		// Resets override everything
		if (cmd[`UTC_CMD_TX_RST]) begin
			next_r.tx_en = 1'b0;
			next_r.brk = 1'b0;
			next_r.ts = TX_IDLE;
			next_r.tline = 1'b1;
			next_r.twp = 8'h00;
			next_r.trp = 8'h00;
			next_r.tcnt = 9'h000;
		end
		if (cmd[`UTC_CMD_RX_RST]) begin
			next_r.rx_en = 1'b0;
			next_r.rs = RX_IDLE;
			next_r.rwp = 8'h00;
			next_r.rrp = 8'h00;
			next_r.rcnt = 9'h000;
			next_r.ovr = 1'b0;
		end
		////////////////////////////////////////////////////////////////////////
		// Flags and outputs
		next_r.txd = next_r.tline & ~next_r.brk;
		next_r.space = next_r.tx_en & (next_r.tcnt != `UTC_QUEUE_FULL);
		next_r.drained = next_r.space & (next_r.tcnt == 9'h000) & (next_r.ts == TX_IDLE);
		next_r.rts_n = ~(next_r.mr2[`UTC_MR2_RTS] & ((next_r.tcnt != 9'h000) | (next_r.ts != TX_IDLE)));
		next_r.irq_n = ~((next_r.space & next_r.interrupt_mask_reg[0]) | ((next_r.rcnt != 9'h000) & next_r.interrupt_mask_reg[1]));
		next_r.bid = 8'hFF - next_r.tcnt[7:0];
		case (next_r.mr0[`UTC_MR0_LVL_LO +: 2])
			2'h0: next_r.bid_v = next_r.space;
			2'h1: next_r.bid_v = next_r.space & (next_r.tcnt <= `UTC_LVL_240);
			2'h2: next_r.bid_v = next_r.space & (next_r.tcnt <= `UTC_LVL_16);
			default: next_r.bid_v = next_r.space & (next_r.tcnt == 9'h000);
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			r <= '0;
			r.waitrequest <= 1'b1;
			r.tline <= 1'b1;
			r.txd <= 1'b1;
			r.rts_n <= 1'b1;
			r.irq_n <= 1'b1;
			r.div <= `UTC_DIV_RST;
			r.rxs <= 3'h7;
			r.rxf <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_drained_space: assert property (@(posedge clk_i) disable iff (reset_i)
		r.drained |-> r.space) else $error("drained without space");
	a_flags_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
		!r.tx_en |-> !r.space && !r.drained) else $error("flags set while disabled");
	a_write_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
		bus_wr && av_i.address == `UTC_OFF_DATA && !r.tx_en && r.ts != TX_IDLE
		|=> r.tcnt == $past(r.tcnt) || r.tcnt + 9'h001 == $past(r.tcnt))
		else $error("write accepted while disabled");
	a_load_clears: assert property (@(posedge clk_i) disable iff (reset_i)
		bus_wr && av_i.address == `UTC_OFF_DATA && r.tx_en && r.tcnt == 9'h000
		|=> !r.drained && r.tcnt == 9'h001) else $error("load did not clear drained");
	a_tx_reset: assert property (@(posedge clk_i) disable iff (reset_i)
		bus_wr && av_i.address == `UTC_OFF_CMD && av_i.writedata[`UTC_CMD_TX_RST]
		|=> r.txd && r.tcnt == 9'h000 && !r.space && r.ts == TX_IDLE)
		else $error("transmitter reset incomplete");
	a_break_low: assert property (@(posedge clk_i) disable iff (reset_i)
		r.brk |-> !r.txd) else $error("line high during break");
	a_start_soon: assert property (@(posedge clk_i) disable iff (reset_i)
		r.ts == TX_IDLE && ttick && r.tcnt != 9'h000 && !(r.mr2[`UTC_MR2_CTS] && r.ctsf)
		&& !(bus_wr && av_i.address == `UTC_OFF_CMD)
		|=> r.ts == TX_START ##1 !r.txd || r.brk) else $error("start bit late");
	a_cts_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		r.ts == TX_IDLE && r.mr2[`UTC_MR2_CTS] && r.ctsf |=> r.ts == TX_IDLE)
		else $error("sent while clear-to-send high");
	a_bid_full: assert property (@(posedge clk_i) disable iff (reset_i)
		r.tcnt == `UTC_QUEUE_FULL |-> !r.bid_v && !r.space) else $error("full queue bids");
	a_rx_unused: assert property (@(posedge clk_i) disable iff (reset_i)
		r.rs == RX_STOP && rbend && r.mr1[1:0] != 2'h3 |=> (r.rxq[$past(r.rwp)][7:0]
		& ~len_mask($past(r.mr1[1:0]))) == 8'h00 || r.ovr) else $error("unused bits set");
endmodule

// ==== verif/test_uart_tx_rx_channel.sv ====
// Self-checking bench of the UART channel against a queue model
`include "utc_defines.svh"
module test_uart_tx_rx_channel import utc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	utc_av_req_type av_i = '0;
	utc_av_rsp_type av_o;
	logic cts = 1'b0;
	logic send = 1'b0;
	logic [7:0] send_byte = 8'h00;
	logic [3:0] ext_cnt = 4'h0;
	logic txd_o;
	logic rxd;
	logic send_request_n_o;
	logic host_interrupt_n_o;
	logic tx_bid_valid_o;
	logic got;
	logic [7:0] tx_bid_o;
	logic [7:0] got_byte;
	logic [31:0] rd;
	logic [31:0] seed = 32'h1B5BD027;
	int n_errors = 0;
	int n_checks = 0;
	int n;
	logic [7:0] exp_q[$];
	logic [7:0] rx_q[$];
	always #20 clk_i = ~clk_i;
	// Free-running external bit clock: one rising edge every 16 clocks
	always @(posedge clk_i) begin
		ext_cnt <= ext_cnt + 4'h1;
	end
	utc_channel utc_channel_i (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.av_i(av_i),
		.av_o(av_o),
		.rxd_i(rxd),
		.aux_pin_zero_i(cts),
		.ext_clk_i(ext_cnt[3]),
		.txd_o(txd_o),
		.send_request_n_o(send_request_n_o),
		.host_interrupt_n_o(host_interrupt_n_o),
		.tx_bid_o(tx_bid_o),
		.tx_bid_valid_o(tx_bid_valid_o)
	);
	utc_remote utc_remote_i (
		.clk_i(clk_i),
		.txd_i(txd_o),
		.rxd_o(rxd),
		.send_i(send),
		.send_byte_i(send_byte),
		.got_o(got),
		.got_byte_o(got_byte)
	);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	// Avalon cycle: hold the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		av_i.write <= w;
		av_i.read <= !w;
		av_i.address <= a;
		av_i.writedata <= d;
		av_i.byteenable <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (av_o.waitrequest !== 1'b0);
		rd = av_o.readdata;
		av_i.write <= 1'b0;
		av_i.read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(what, e, rd);
	endtask
	task automatic load(input logic [7:0] b);
		exp_q.push_back(b);
		wr(`UTC_OFF_DATA, {24'h0, b});
	endtask
	task automatic drain;
		n = 0;
		while (exp_q.size() != 0 && n < 5000) begin
			tick(1);
			n++;
		end
		chk("model queue left", 32'h0, 32'(exp_q.size()));
	endtask
	task automatic wait_low;
		n = 0;
		while (txd_o !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
	endtask
	task automatic rx_send(input logic [7:0] b);
		send_byte <= b;
		send <= 1'b1;
		tick(1);
		send <= 1'b0;
		tick(165);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Characters seen on the line against the model order
	always @(posedge clk_i) begin
		if (got === 1'b1) begin
			chk("serial byte", exp_q.size() ? exp_q.pop_front() : 9'h100, got_byte);
		end
	end
	initial begin
		tick(40000);
		n_errors++;
		$display("FAIL watchdog expected finish seen timeout");
		conclude();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(8);
		reset_i <= 1'b0;
		tick(4);
		rdchk("status", `UTC_OFF_STAT, 32'h0);
		chk("txd idle", 32'h1, txd_o);
		$display("test reset done");
		wr(`UTC_OFF_DIV, 32'h0);
		wr(`UTC_OFF_MR1, 32'h3);
		wr(`UTC_OFF_MR2, 32'h30);
		wr(`UTC_OFF_DATA, 32'h55);
		wr(`UTC_OFF_CMD, 32'h1);
		tick(2);
		rdchk("status", `UTC_OFF_STAT, 32'h2C);
		rdchk("bid", `UTC_OFF_BID, 32'h1FF);
		chk("bid port", 32'h1FF, {tx_bid_valid_o, tx_bid_o});
		wr(`UTC_OFF_IMR, 32'h1);
		tick(2);
		chk("irq", 32'h0, host_interrupt_n_o);
		$display("test enable done");
		seed = lfsr(seed);
		load(seed[7:0]);
		wait_low();
		chk("start delay", 32'h1, n <= 4);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			load(seed[7:0]);
		end
		rdchk("status", `UTC_OFF_STAT, 32'h24);
		chk("rts busy", 32'h0, send_request_n_o);
		drain();
		tick(20);
		rdchk("status", `UTC_OFF_STAT, 32'h2C);
		chk("rts done", 32'h1, send_request_n_o);
		$display("test stream done");
		cts <= 1'b1;
		tick(6);
		load(8'hA5);
		tick(400);
		chk("cts hold", 32'h1, 32'(exp_q.size()));
		wr(`UTC_OFF_MR0, 32'h30);
		rdchk("bid empty only", `UTC_OFF_BID, 32'h0FE);
		chk("bid port", 32'h0FE, {tx_bid_valid_o, tx_bid_o});
		wr(`UTC_OFF_MR0, 32'h20);
		rdchk("bid level 16", `UTC_OFF_BID, 32'h1FE);
		chk("bid port", 32'h1FE, {tx_bid_valid_o, tx_bid_o});
		wr(`UTC_OFF_MR0, 32'h0);
		cts <= 1'b0;
		drain();
		$display("test flow done");
		load(8'h3C);
		load(8'hC3);
		wr(`UTC_OFF_CMD, 32'h2);
		tick(2);
		rdchk("status", `UTC_OFF_STAT, 32'h0);
		wr(`UTC_OFF_DATA, 32'h99);
		drain();
		tick(300);
		$display("test disable done");
		wr(`UTC_OFF_CMD, 32'h1);
		wr(`UTC_OFF_CMD, 32'h8);
		tick(2);
		n = 0;
		repeat (200) begin
			tick(1);
			n += (txd_o === 1'b0);
		end
		chk("break cycles", 32'd200, n);
		wr(`UTC_OFF_CMD, 32'h10);
		tick(4);
		chk("break end", 32'h1, txd_o);
		$display("test break done");
		cts <= 1'b1;
		tick(6);
		wr(`UTC_OFF_DATA, 32'h11);
		wr(`UTC_OFF_DATA, 32'h22);
		cts <= 1'b0;
		wait_low();
		wr(`UTC_OFF_CMD, 32'h4);
		tick(2);
		chk("reset line", 32'h1, txd_o);
		rdchk("status", `UTC_OFF_STAT, 32'h0);
		wr(`UTC_OFF_CMD, 32'h1);
		tick(400);
		$display("test tx reset done");
		wr(`UTC_OFF_MR1, 32'h6);
		seed = lfsr(seed);
		exp_q.push_back({^seed[6:0], seed[6:0]});
		wr(`UTC_OFF_DATA, {24'h0, seed[7:0]});
		drain();
		tick(20);
		wr(`UTC_OFF_MR1, 32'h3);
		$display("test parity done");
		wr(`UTC_OFF_TCS, 32'h2);
		seed = lfsr(seed);
		load(seed[7:0]);
		drain();
		tick(20);
		wr(`UTC_OFF_TCS, 32'h3);
		seed = lfsr(seed);
		load(seed[7:0]);
		wait_low();
		chk("start delay 1x", 32'h1, n <= 32);
		drain();
		tick(20);
		wr(`UTC_OFF_TCS, 32'h0);
		$display("test clock mode done");
		wr(`UTC_OFF_CMD, 32'h20);
		for (int k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			rx_q.push_back(seed[7:0]);
			rx_send(seed[7:0]);
		end
		wr(`UTC_OFF_IMR, 32'h2);
		tick(2);
		chk("irq rx", 32'h0, host_interrupt_n_o);
		rdchk("rx entry", `UTC_OFF_DATA, {24'h0, rx_q.pop_front()});
		rdchk("rx entry", `UTC_OFF_DATA, {24'h0, rx_q.pop_front()});
		wr(`UTC_OFF_MR1, 32'h2);
		rx_send(8'hFF);
		rdchk("rx short", `UTC_OFF_DATA, 32'h7F);
		rdchk("rx empty", `UTC_OFF_DATA, 32'h0);
		tick(2);
		chk("irq idle", 32'h1, host_interrupt_n_o);
		$display("test receive done");
		conclude();
	end
endmodule

// ==== verif/utc_remote.sv ====
// Remote serial partner: decodes the transmit line and sends frames on the receive line
module utc_remote #(
	parameter int BIT = 16
) (
	// Clock
	input wire logic clk_i,
	// Serial lines
	input wire logic txd_i,
	output logic rxd_o,
	// Bench side
	input wire logic send_i,
	input wire logic [7:0] send_byte_i,
	output logic got_o,
	output logic [7:0] got_byte_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	logic [7:0] tsh;
	initial begin
		rxd_o = 1'b1;
		got_o = 1'b0;
		got_byte_o = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Hunt start, check it at mid-bit, sample LSB first, report only with a high stop
	always begin
		@(posedge clk_i);
		if (txd_i === 1'b0) begin
			repeat (BIT / 2) @(posedge clk_i);
			if (txd_i === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(posedge clk_i);
					sh[i] = txd_i;
				end
				repeat (BIT) @(posedge clk_i);
				if (txd_i === 1'b1) begin
					got_byte_o <= sh;
					got_o <= 1'b1;
					@(posedge clk_i);
					got_o <= 1'b0;
				end else begin
					wait (txd_i === 1'b1);
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Send one frame: start, eight data bits LSB first, one stop, idle high
	always begin
		@(posedge clk_i);
		if (send_i === 1'b1) begin
			tsh = send_byte_i;
			rxd_o <= 1'b0;
			repeat (BIT) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				rxd_o <= tsh[i];
				repeat (BIT) @(posedge clk_i);
			end
			rxd_o <= 1'b1;
			repeat (BIT) @(posedge clk_i);
		end
	end
endmodule
